/* File: hw/puc_counter_ctrl.sv */
// Purpose: Controlling logic of one counter stage, run from software.
// Assumes: Classic Wishbone slave with 32-bit data and byte addresses.
// Notes:   All fields sit in byte lane 0; other lanes are ignored.
`timescale 1ns/1ns
module puc_counter_ctrl (
	input  wire logic        sys_clk_i, // System clock, 100 MHz.
	input  wire logic        rst_i,     // Synchronous reset, high.
	input  wire logic        ce_i,      // Clock enable, high.
	input  wire logic [3:0]  wb_adr_i,  // Byte address.
	input  wire logic [31:0] wb_dat_i,  // Write data.
	input  wire logic        wb_we_i,   // Write enable.
	input  wire logic [3:0]  wb_sel_i,  // Byte selects.
	input  wire logic        wb_cyc_i,  // Cycle.
	input  wire logic        wb_stb_i,  // Strobe.
	output logic [31:0]      wb_dat_o,  // Read data.
	output logic             wb_ack_o,  // Acknowledge.
	output logic             irq_o,     // Interrupt, high.
	puc_link_if.ctrl         link       // Pins toward the counter.
);

	logic [7:0]              ctrl;
	logic [1:0]              int_stat;
	logic [1:0]              int_mask;
	logic [31:0]             dat;
	logic                    ack;
	logic                    irq;
	logic                    cp;
	logic [2:0]              cp_cnt;
	logic                    ce_n;
	logic                    down;
	logic                    load_n;
	logic [3:0]              preset;
	logic [2:0]              ld_cnt;
	puc_pkg::puc_ld_state_t  ld_state;
	logic                    tc_q;
	logic                    rc_q;

	wire        req      = wb_cyc_i & wb_stb_i;
	wire        wr_take  = req & ack & wb_we_i & wb_sel_i[0];
	wire        wr_ctrl  = wr_take & (wb_adr_i == puc_pkg::REG_CTRL);
	wire        wr_clr   = wr_take & (wb_adr_i == puc_pkg::REG_INT_STAT);
	wire        wr_mask  = wr_take & (wb_adr_i == puc_pkg::REG_INT_MASK);
	wire        load_req = wr_ctrl & wb_dat_i[puc_pkg::CTRL_LOAD_BIT];
	wire        cp_wrap  = (cp_cnt == puc_pkg::CP_HALF_CYC - 3'h1);
	wire        cp_hold  = cp & ~cp_wrap;
	wire        run_req  = ctrl[puc_pkg::CTRL_RUN_BIT];
	wire        dn_req   = ctrl[puc_pkg::CTRL_DOWN_BIT];
	wire        next_ce_n = run_req ? 1'b0
	                      : (cp_hold ? 1'b1 : ce_n);
	wire        dir_ok   = cp_hold | (ce_n & next_ce_n);
	wire [1:0]  ev       = {rc_q & ~link.ripple_clock_n,
	                        link.terminal_flag & ~tc_q};
	wire [1:0]  next_int = (int_stat & ~(wr_clr ? wb_dat_i[1:0] : 2'h0))
	                     | ev;
	wire [31:0] rd_data  =
		(wb_adr_i == puc_pkg::REG_CTRL)     ? {24'h0, ctrl} :
		(wb_adr_i == puc_pkg::REG_STATUS)   ? {26'h0, ~ce_n,
		                                       link.terminal_flag,
		                                       link.count_out} :
		(wb_adr_i == puc_pkg::REG_INT_STAT) ? {30'h0, int_stat} :
		(wb_adr_i == puc_pkg::REG_INT_MASK) ? {30'h0, int_mask} :
		32'h0;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			dat <= 32'h0;
		end else if (ce_i) begin
			ack <= req & ~ack;
			dat <= rd_data;
		end
	end

	// The load bit is a command and always reads back as zero.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ctrl <= puc_pkg::CTRL_RESET;
		end else if (ce_i && wr_ctrl) begin
			ctrl <= wb_dat_i[7:0] & 8'hFB;
		end
	end

	// A new event wins over a clear in the same cycle.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			int_stat <= puc_pkg::INT_RESET;
			int_mask <= puc_pkg::INT_RESET;
			irq      <= 1'b0;
			tc_q     <= 1'b0;
			rc_q     <= 1'b1;
		end else if (ce_i) begin
			int_stat <= next_int;
			int_mask <= wr_mask ? wb_dat_i[1:0] : int_mask;
			irq      <= |(next_int & (wr_mask ? wb_dat_i[1:0] : int_mask));
			tc_q     <= link.terminal_flag;
			rc_q     <= link.ripple_clock_n;
		end
	end

	// Free-running count clock; one phase lasts CP_HALF_CYC cycles.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cp     <= 1'b1;
			cp_cnt <= 3'h0;
		end else if (ce_i) begin
			cp_cnt <= cp_wrap ? 3'h0 : cp_cnt + 3'h1;
			cp     <= cp_wrap ? ~cp : cp;
		end
	end

	// Counting starts at any moment and stops only in a high phase.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ce_n <= 1'b1;
			down <= 1'b0;
		end else if (ce_i) begin
			ce_n <= next_ce_n;
			down <= dir_ok ? dn_req : down;
		end
	end

	// Preset pulse held long enough for the documented minimum width.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ld_state <= puc_pkg::LD_IDLE;
			ld_cnt   <= 3'h0;
			load_n   <= 1'b1;
			preset   <= 4'h0;
		end else if (ce_i) begin
			case (ld_state)
				puc_pkg::LD_IDLE: begin
					if (load_req) begin
						preset   <= wb_dat_i[puc_pkg::CTRL_PRESET_LSB +: 4];
						load_n   <= 1'b0;
						ld_cnt   <= puc_pkg::LOAD_CYC - 3'h1;
						ld_state <= puc_pkg::LD_PULSE;
					end
				end
				puc_pkg::LD_PULSE: begin
					if (ld_cnt == 3'h0) begin
						load_n   <= 1'b1;
						ld_state <= puc_pkg::LD_IDLE;
					end else begin
						ld_cnt <= ld_cnt - 3'h1;
					end
				end
				default: begin
					load_n   <= 1'b1;
					ld_state <= puc_pkg::LD_IDLE;
				end
			endcase
		end
	end

	// The enable alone inhibits a single stage; cascades add it to
	// every carry gate.
	assign link.count_enable_n = ce_n;
	assign link.cp             = cp;
	assign link.count_down     = down;
	assign link.async_load_n   = load_n;
	assign link.preset_data    = preset;
	assign wb_dat_o            = dat;
	assign wb_ack_o            = ack;
	assign irq_o               = irq;

endmodule : puc_counter_ctrl

/* File: hw/puc_counter_dev.sv */
// Purpose: One four-bit presettable up/down counter stage.
// Assumes: Link inputs come from logic on the same system clock.
// Notes:   The count clock is sampled; its rising edge is found by
//          comparing it with its value one system clock earlier.
//          The preset is taken on the system clock, so it shows one
//          cycle after the load pin falls rather than at once.
`timescale 1ns/1ns

// Overview of operation
// - Four-bit state, decade or binary build.
// - Load low copies preset data into state.
// - Load overrides enable, direction and clock.
// - Enabled state changes only on clock rise.
// - Enable high holds the count.
// - Direction low counts up, high down.
// - Controller may lower enable any time.
// - Controller raises enable only while clock high.
// - Direction changes only with enable or clock high.
// - Terminal flag high at zero down, maximum up.
// - Terminal flag holds until state or direction changes.
// - Terminal flag ignores this stage's enable.
// - Ripple clock low during enabled terminal clock-low.
// - Ripple clock high if disabled or not terminal.
// - Terminal flag is never used as a clock.
// - Ripple clock may clock the next stage.
// - Parallel clocking needs a long enough low phase.
// - Gated carries each include an inhibit term.
module puc_counter_dev #(
	parameter bit DECADE = 1'b0 // 1 for the decade build, 0 for binary.
) (
	input  wire logic       sys_clk_i,     // System clock, 100 MHz.
	input  wire logic       rst_i,         // Synchronous reset, high.
	input  wire logic       ce_i,          // Clock enable, high.
	puc_link_if.dev         link,          // Pins toward the controller.
	output logic [3:0]      count_o,       // Count state for local use.
	output logic            terminal_o,    // Terminal flag copy.
	output logic            carry_pulse_o  // Pulse as ripple clock falls.
);

	// Highest state of the selected build.
	localparam logic [3:0] MAX_COUNT =
		DECADE ? puc_pkg::MAX_DECADE : puc_pkg::MAX_BINARY;

	// True when the state sits at the end of the count direction.
	function automatic logic is_terminal(
		input logic [3:0] cnt,
		input logic       down
	);
		logic hit;
		if (down) begin
			hit = (cnt == puc_pkg::COUNT_ZERO);
		end else begin
			hit = (cnt == MAX_COUNT);
		end
		return hit;
	endfunction : is_terminal

	// State reached by a step off either end of the count.
	function automatic logic [3:0] wrap_to(
		input logic down
	);
		logic [3:0] val;
		if (down) begin
			val = MAX_COUNT;
		end else begin
			val = puc_pkg::COUNT_ZERO;
		end
		return val;
	endfunction : wrap_to

	// Next state of one count step, wrapping at both ends.
	function automatic logic [3:0] count_step(
		input logic [3:0] cnt,
		input logic       down
	);
		logic [3:0] nxt;
		if (down) begin
			if (is_terminal(cnt, 1'b1)) begin
				nxt = wrap_to(1'b1);
			end else begin
				nxt = cnt - puc_pkg::COUNT_ONE;
			end
		end else begin
			// A decade state above nine also returns to zero.
			if (cnt >= MAX_COUNT) begin
				nxt = wrap_to(1'b0);
			end else begin
				nxt = cnt + puc_pkg::COUNT_ONE;
			end
		end
		return nxt;
	endfunction : count_step

	// State flip-flops.
	logic [3:0] count;
	logic       tc;
	logic       rc_n;
	logic       cp_q;
	logic       carry_pulse;

	// Decode and next-state nets.
	wire        load_act;
	wire        count_en;
	wire        cp_rise;
	wire        count_act;
	wire [3:0]  stepped;
	wire [3:0]  next_count;
	wire        next_tc;
	wire        rc_arm;
	wire        rc_low;
	wire        next_rc_n;
	wire        next_carry_pulse;

	// The preset acts on every system clock while it is held low,
	// so no count clock is needed for it.
	assign load_act = ~link.async_load_n;

	// Shared by the step and the ripple clock decode.
	assign count_en = ~link.count_enable_n;

	// A rise is the count clock high now and low one cycle earlier.
	assign cp_rise = link.cp & ~cp_q;

	assign count_act = ~load_act
	                 & count_en
	                 & cp_rise;

	assign stepped = count_step(count, link.count_down);

	// Every state bit takes the same branch: preset, step or hold.
	for (genvar b = 0; b < puc_pkg::CNT_W; b++) begin : g_next_bit
		assign next_count[b] = load_act  ? link.preset_data[b]
		                     : count_act ? stepped[b]
		                     : count[b];
	end

	// Decoded from state and direction only, so a direction change
	// alone moves it too.
	assign next_tc = is_terminal(next_count, link.count_down);

	// Armed only while enabled and terminal; a disabled or
	// non-terminal stage keeps the ripple clock high.
	assign rc_arm = count_en & tc;

	// Low through the count clock's low phase once armed; it rises
	// again once the count clock has risen.
	assign rc_low = rc_arm & ~link.cp;

	assign next_rc_n = ~rc_low;

	assign next_carry_pulse = rc_n & ~next_rc_n;

	// The sampled clock starts high, as the controller's count clock
	// does, so the release of reset is not taken for a rising edge.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cp_q <= 1'b1;
		end else if (ce_i) begin
			cp_q <= link.cp;
		end
	end

	// The state loads, steps or holds on each enabled system clock.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			count <= puc_pkg::COUNT_ZERO;
		end else if (ce_i) begin
			count <= next_count;
		end
	end

	// The flag is registered in step with the state it decodes.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tc <= 1'b0;
		end else if (ce_i) begin
			tc <= next_tc;
		end
	end

	// Registered, so the next stage never sees a decode glitch on
	// the ripple clock, which it may take as its count clock.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rc_n <= 1'b1;
		end else if (ce_i) begin
			rc_n <= next_rc_n;
		end
	end

	// One cycle of pulse as the ripple clock falls, for local use.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			carry_pulse <= 1'b0;
		end else if (ce_i) begin
			carry_pulse <= next_carry_pulse;
		end
	end

	// The flag stays put between state or direction changes because
	// it is recomputed from those two alone.
	assign link.terminal_flag  = tc;
	assign link.count_out      = count;
	assign link.ripple_clock_n = rc_n;
	assign count_o             = count;
	assign terminal_o          = tc;
	assign carry_pulse_o       = carry_pulse;

endmodule : puc_counter_dev

/* File: pkg/puc_link_if.sv */
// Purpose: Pin bundle between a counter stage and its controlling logic.
// Assumes: Every signal is driven from a flip-flop on the system clock.
// Notes:   No two-way pins; each signal has one driver.
`timescale 1ns/1ns
interface puc_link_if;
	logic       cp;             // Count clock from the controller.
	logic       async_load_n;   // Preset strobe, active low.
	logic       count_enable_n; // Count enable, active low.
	logic       count_down;     // Direction: 0 up, 1 down.
	logic [3:0] preset_data;    // Value copied in during preset.
	logic [3:0] count_out;      // Count state.
	logic       terminal_flag;  // Terminal count indication.
	logic       ripple_clock_n; // Ripple clock, active low.

	modport dev (
		input  cp,
		input  async_load_n,
		input  count_enable_n,
		input  count_down,
		input  preset_data,
		output count_out,
		output terminal_flag,
		output ripple_clock_n
	);

	modport ctrl (
		output cp,
		output async_load_n,
		output count_enable_n,
		output count_down,
		output preset_data,
		input  count_out,
		input  terminal_flag,
		input  ripple_clock_n
	);
endinterface : puc_link_if

/* File: pkg/puc_pkg.sv */
// Purpose: Shared constants and types of the presettable up/down counter.
// Assumes: Both ends run on one 100 MHz system clock.
// Notes:   Register offsets are byte addresses on the controller bus.
package puc_pkg;
	localparam int CNT_W = 4;
	localparam logic [3:0] MAX_DECADE = 4'h9;
	localparam logic [3:0] MAX_BINARY = 4'hF;
	localparam logic [3:0] COUNT_ZERO = 4'h0;
	localparam logic [3:0] COUNT_ONE  = 4'h1;

	localparam int CLK_PERIOD_NS = 10;
	localparam int CP_PERIOD_NS  = 80;
	localparam int LOAD_PULSE_NS = 35;
	localparam logic [2:0] CP_HALF_CYC =
		3'(CP_PERIOD_NS / (2 * CLK_PERIOD_NS));
	localparam logic [2:0] LOAD_CYC =
		3'((LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam logic [3:0] REG_CTRL     = 4'h0;
	localparam logic [3:0] REG_STATUS   = 4'h4;
	localparam logic [3:0] REG_INT_STAT = 4'h8;
	localparam logic [3:0] REG_INT_MASK = 4'hC;

	localparam int CTRL_RUN_BIT    = 0;
	localparam int CTRL_DOWN_BIT   = 1;
	localparam int CTRL_LOAD_BIT   = 2;
	localparam int CTRL_PRESET_LSB = 4;
	localparam int STAT_TC_BIT     = 4;
	localparam int STAT_RUN_BIT    = 5;
	localparam int INT_TC_BIT      = 0;
	localparam int INT_RC_BIT      = 1;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] INT_RESET  = 2'h0;

	typedef enum logic [1:0] {
		LD_IDLE  = 2'h1,
		LD_PULSE = 2'h2
	} puc_ld_state_t;
endpackage : puc_pkg

/* File: test/puc_link_chk.sv */
// Purpose: Assertions on the link between a counter stage and its controller.
// Assumes: One clock domain; reset synchronous, active high.
// Notes:   The wrap point follows the DECADE build of the stage.
`timescale 1ns/1ns
module puc_link_chk #(
	parameter bit DECADE = 1'b1 // Build of the watched stage.
) (
	input wire logic       sys_clk_i,      // System clock.
	input wire logic       rst_i,          // Reset, high.
	input wire logic       cp,             // Count clock.
	input wire logic       async_load_n,   // Preset, low.
	input wire logic       count_enable_n, // Enable, low.
	input wire logic       count_down,     // Direction.
	input wire logic [3:0] preset_data,    // Preset value.
	input wire logic [3:0] count_out,      // Count state.
	input wire logic       terminal_flag,  // Terminal flag.
	input wire logic       ripple_clock_n  // Ripple clock, low.
);
	localparam logic [3:0] MAX = DECADE ? 4'h9 : 4'hF;

	function automatic logic [3:0] nxt(input logic [3:0] c, input logic d);
		if (d)
			return (c == 4'h0) ? MAX : c - 4'h1;
		return (c >= MAX) ? 4'h0 : c + 4'h1;
	endfunction : nxt

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	load_copy_a: assert property (
		!async_load_n |=> count_out == $past(preset_data))
		else $error("preset not copied");
	count_hold_a: assert property (
		async_load_n && !(!count_enable_n && $rose(cp)) |=>
		$stable(count_out)) else $error("count moved");
	count_step_a: assert property (
		async_load_n && !count_enable_n && $rose(cp) |=>
		count_out == nxt($past(count_out), $past(count_down)))
		else $error("wrong step");
	tc_decode_a: assert property (
		$stable(count_out) && $stable(count_down) |-> terminal_flag ==
		(count_down ? count_out == 4'h0 : count_out == MAX))
		else $error("terminal flag wrong");
	rc_low_a: assert property (
		!cp && !count_enable_n && terminal_flag |=> !ripple_clock_n)
		else $error("ripple clock not low");
	rc_high_a: assert property (
		cp || count_enable_n || !terminal_flag |=> ripple_clock_n)
		else $error("ripple clock not high");
	stop_phase_a: assert property (
		$rose(count_enable_n) |-> cp && $past(cp))
		else $error("stop outside clock high");
	dir_change_a: assert property (
		$changed(count_down) |->
		(count_enable_n && $past(count_enable_n)) || (cp && $past(cp)))
		else $error("direction changed while counting");
endmodule : puc_link_chk

/* File: test/test_presettable_updown_counter.sv */
// Purpose: Self-checking bench of the controller and one counter stage.
// Assumes: Decade build; ce_i held high on both ends.
// Notes:   A reference model follows the link pins to predict the count.
`timescale 1ns/1ns
module test_presettable_updown_counter;
	localparam logic [3:0] MAX = puc_pkg::MAX_DECADE;
	logic        sys_clk_i;
	logic        rst_i;
	logic [3:0]  wb_adr;
	logic [31:0] wb_wdat;
	logic        wb_we;
	logic [3:0]  wb_sel;
	logic        wb_cyc;
	logic        wb_stb;
	logic [31:0] wb_rdat;
	logic        wb_ack;
	logic        irq;
	logic [3:0]  ref_cnt;
	logic        cp_q;
	logic [31:0] rd;
	logic [3:0]  p;
	logic        dn;
	logic [3:0]  dev_cnt;
	logic        dev_tc;
	logic        dev_carry;
	int          n_carry = 0;
	int          c0;
	int          fails;
	int          n_tests;

	puc_link_if u_puc_link_if ();
	puc_counter_ctrl u_puc_counter_ctrl (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_we_i(wb_we),
		.wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq),
		.link(u_puc_link_if));
	puc_counter_dev #(.DECADE(1'b1)) u_puc_counter_dev (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.link(u_puc_link_if), .count_o(dev_cnt), .terminal_o(dev_tc),
		.carry_pulse_o(dev_carry));
	puc_link_chk #(.DECADE(1'b1)) u_puc_link_chk (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cp(u_puc_link_if.cp),
		.async_load_n(u_puc_link_if.async_load_n),
		.count_enable_n(u_puc_link_if.count_enable_n),
		.count_down(u_puc_link_if.count_down),
		.preset_data(u_puc_link_if.preset_data),
		.count_out(u_puc_link_if.count_out),
		.terminal_flag(u_puc_link_if.terminal_flag),
		.ripple_clock_n(u_puc_link_if.ripple_clock_n));

	function automatic logic [3:0] step_of(input logic [3:0] c,
		input logic d);
		if (d)
			return (c == 4'h0) ? MAX : c - 4'h1;
		return (c >= MAX) ? 4'h0 : c + 4'h1;
	endfunction : step_of

	always @(posedge sys_clk_i) begin
		cp_q <= u_puc_link_if.cp;
		if (dev_carry)
			n_carry <= n_carry + 1;
		if (rst_i)
			ref_cnt <= 4'h0;
		else if (!u_puc_link_if.async_load_n)
			ref_cnt <= u_puc_link_if.preset_data;
		else if (!u_puc_link_if.count_enable_n && u_puc_link_if.cp && !cp_q)
			ref_cnt <= step_of(ref_cnt, u_puc_link_if.count_down);
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wb(input logic [3:0] a, input logic w,
		input logic [31:0] d);
		@(posedge sys_clk_i);
		wb_adr  <= a;
		wb_we   <= w;
		wb_wdat <= d;
		wb_cyc  <= 1'b1;
		wb_stb  <= 1'b1;
		do begin
			@(posedge sys_clk_i);
		end while (wb_ack !== 1'b1);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb

	task automatic chk_stat();
		logic [31:0] e;
		wb(puc_pkg::REG_STATUS, 1'b0, 32'h0);
		e = {27'h0, dn ? ref_cnt == 4'h0 : ref_cnt == MAX, ref_cnt};
		chk(rd, e);
		chk({27'h0, dev_tc, dev_cnt}, e);
	endtask : chk_stat

	task automatic chk_irq(input logic e);
		repeat (3) @(posedge sys_clk_i);
		chk({31'h0, irq}, {31'h0, e});
	endtask : chk_irq

	task automatic conclude();
		$display("Counts: tests=%0d mismatches=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		fails++;
		conclude();
	end

	initial begin
		rst_i   = 1'b1;
		wb_adr  = 4'h0;
		wb_wdat = 32'h0;
		wb_we   = 1'b0;
		wb_sel  = 4'hF;
		wb_cyc  = 1'b0;
		wb_stb  = 1'b0;
		fails   = 0;
		n_tests = 0;
		dn      = 1'b0;
		void'($urandom(32'h0948c922));
		repeat (10) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			wb((i == 4) ? 4'h6 : 4'(4 * i), 1'b0, 32'h0);
			chk(rd, 32'h0);
		end
		$display("Test reset done");
		for (int k = 0; k < 8; k++) begin
			p  = (k < 2) ? (k[0] ? 4'h0 : MAX) : 4'($urandom_range(9));
			dn = (k < 2) ? k[0] : 1'($urandom_range(1));
			wb(puc_pkg::REG_CTRL, 1'b1, {24'h0, p, 2'h1, dn, 1'b0});
			repeat (8) @(posedge sys_clk_i);
			chk_stat();
			wb(puc_pkg::REG_CTRL, 1'b0, 32'h0);
			chk(rd, {24'h0, p, 2'h0, dn, 1'b0});
			wb(puc_pkg::REG_CTRL, 1'b1, {24'h0, p, 2'h0, dn, 1'b1});
			repeat ($urandom_range(60, 10)) @(posedge sys_clk_i);
			wb(puc_pkg::REG_CTRL, 1'b1, {24'h0, p, 2'h0, dn, 1'b0});
			repeat (16) @(posedge sys_clk_i);
			chk_stat();
			repeat (16) @(posedge sys_clk_i);
			chk_stat();
		end
		$display("Test count done");
		wb(puc_pkg::REG_INT_STAT, 1'b1, 32'h3);
		wb(puc_pkg::REG_INT_MASK, 1'b1, 32'h1);
		wb(puc_pkg::REG_CTRL, 1'b1, 32'h84);
		c0 = n_carry;
		wb(puc_pkg::REG_CTRL, 1'b1, 32'h81);
		repeat (40) @(posedge sys_clk_i);
		wb(puc_pkg::REG_CTRL, 1'b1, 32'h80);
		repeat (16) @(posedge sys_clk_i);
		wb(puc_pkg::REG_INT_STAT, 1'b0, 32'h0);
		chk(rd, 32'h3);
		chk(n_carry - c0, 32'h1);
		chk_irq(1'b1);
		wb(puc_pkg::REG_INT_STAT, 1'b1, 32'h1);
		chk_irq(1'b0);
		wb(puc_pkg::REG_INT_MASK, 1'b1, 32'h2);
		chk_irq(1'b1);
		wb(puc_pkg::REG_INT_MASK, 1'b1, 32'h0);
		chk_irq(1'b0);
		wb(puc_pkg::REG_INT_STAT, 1'b1, 32'h2);
		wb(puc_pkg::REG_INT_STAT, 1'b0, 32'h0);
		chk(rd, 32'h0);
		$display("Test interrupt done");
		conclude();
	end
endmodule : test_presettable_updown_counter
